// [core/sim_supply_integrity_monitor.sv]
// supply integrity monitor: undervoltage reset, reset cause flag, supply warning interrupt and apb registers
// ============================================================
// Overview of operation
// - hold static internal reset while undervoltage comparator reports low supply
// - drive external reset pin low while undervoltage reset is active
// - undervoltage reset clears the watchdog reset cause flag
// - detector enabled by option input; threshold level chosen by option input
// - cause flag bit 2 set by undervoltage reset, cleared on software read
// - external and watchdog resets leave the cause flag untouched
// - cause flag undefined when detector disabled by option
// - flag may miss short dropouts or slow external clocks
// - warning flag read only, follows synchronised comparator output live
// - warning interrupt requested on both comparator crossings
// - interrupt reaches cpu only if enabled and global mask clear
// - control/status bit 0 is software read/write interrupt enable
// - pending request cleared when cpu enters the service routine
// - wait mode has no effect; interrupt wakes from wait
// - halt freezes control/status; interrupt cannot wake from halt
// - threshold field 00 low 01 med 10 high 11 off, resets to 11
// - threshold register bits 7:5 hold rc prescaler select, reset zero
// - control/status bits 6:5 hold low oscillator trim bits
module sim_supply_integrity_monitor (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // analog comparators and option settings
    input wire logic uv_cmp_low_i,
    input wire logic warn_cmp_low_i,
    input wire logic uv_detect_enable_i,
    input wire logic [1:0] uv_level_opt_i,
    // other reset sources
    input wire logic wdg_reset_i,
    input wire logic ext_reset_i,
    // cpu state
    input wire logic cpu_irq_mask_i,
    input wire logic irq_vector_ack_i,
    input wire logic halt_mode_i,
    input wire logic wait_mode_i,
    // outputs
    output logic uv_core_reset_o,
    output logic ext_reset_n_o,
    output logic ext_reset_n_oe_o,
    output logic wdg_flag_clear_o,
    output logic [1:0] uv_level_o,
    output logic [1:0] warn_level_o,
    output logic [2:0] rc_prescaler_o,
    output logic [1:0] osc_trim_low_o,
    output logic warn_irq_o,
    output logic warn_wake_o
);
    // ========================================================
    // apb decode
    sim_pkg::sim_apb_req_s req;
    assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    wire access = req.psel & req.penable;
    wire csr_hit = hit(req.paddr, sim_pkg::CSR_ADDR);
    wire thr_hit = hit(req.paddr, sim_pkg::THR_ADDR);
    wire csr_wr = access & req.pwrite & csr_hit;
    wire thr_wr = access & req.pwrite & thr_hit;
    wire csr_rd = access & ~req.pwrite & csr_hit;

    // ========================================================
    // state
    logic uv_rst_reg;
    logic uv_flag_reg;
    logic irq_en_reg;
    logic [1:0] trim_reg;
    logic [1:0] thr_reg;
    logic [2:0] presc_reg;
    logic warn_prev_reg;
    logic pend_reg;
    logic [31:0] prdata_reg;
    logic warn_sync;

    sim_sync u_warn_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(warn_cmp_low_i),
        .sync_o(warn_sync)
    );

    // undervoltage reset only when enabled by option
    wire uv_active = uv_cmp_low_i & uv_detect_enable_i;
    wire csr_frozen = halt_mode_i;
    wire warn_on = (thr_reg != sim_pkg::SIM_THR_OFF);
    wire warn_edge = warn_on & (warn_sync ^ warn_prev_reg);

    wire [7:0] csr_view = {1'b0, trim_reg, 2'b00, uv_flag_reg, warn_sync, irq_en_reg};
    wire [7:0] thr_view = {presc_reg, 3'b000, thr_reg};
    wire [7:0] rd_mux = csr_hit ? csr_view : (thr_hit ? thr_view : 8'h00);

    // ========================================================
    // undervoltage reset and cause flag
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            uv_rst_reg <= 1'b0;
        end else begin
            uv_rst_reg <= uv_active;
        end
    end

    // disabled detector never sets the flag, so its value carries no meaning
    // short dropouts and slow external clocks are not modelled; flag always set
    // set wins over read clear; other resets do not touch it
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            uv_flag_reg <= 1'b0;
        end else if (uv_active) begin
            uv_flag_reg <= 1'b1;
        end else if (csr_rd & ~csr_frozen) begin
            uv_flag_reg <= 1'b0;
        end
    end

    // ========================================================
    // software fields; reserved bits ignored on write
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_en_reg <= 1'b0;
            trim_reg <= sim_pkg::TRIM_RST;
        end else if (csr_wr & ~csr_frozen & ~uv_rst_reg) begin
            irq_en_reg <= req.pwdata[sim_pkg::CSR_IE_BIT];
            trim_reg <= req.pwdata[sim_pkg::CSR_TRIM_LSB +: 2];
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            thr_reg <= sim_pkg::THR_RST;
            presc_reg <= sim_pkg::PRESC_RST;
        end else if (uv_rst_reg) begin
            // back to off under undervoltage reset
            thr_reg <= sim_pkg::THR_RST;
            presc_reg <= sim_pkg::PRESC_RST;
        end else if (thr_wr) begin
            thr_reg <= req.pwdata[sim_pkg::THR_FIELD_LSB +: 2];
            presc_reg <= req.pwdata[sim_pkg::THR_PRESC_LSB +: 3];
        end
    end

    // ========================================================
    // warning interrupt; pending set wins over acknowledge
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            warn_prev_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            warn_prev_reg <= warn_sync;
            if (warn_edge & irq_en_reg) begin
                pend_reg <= 1'b1;
            end else if (irq_vector_ack_i | ~irq_en_reg | uv_rst_reg) begin
                pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_reg <= 32'h0000_0000;
        end else if (access & ~req.pwrite) begin
            prdata_reg <= {24'h00_0000, rd_mux};
        end
    end

    // ========================================================
    // outputs
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~(csr_hit | thr_hit);
    assign prdata_o = (access & ~req.pwrite) ? {24'h00_0000, rd_mux} : prdata_reg;
    assign uv_core_reset_o = uv_rst_reg;
    // external reset pin pulled low, open drain
    assign ext_reset_n_o = 1'b0;
    assign ext_reset_n_oe_o = uv_rst_reg;
    assign wdg_flag_clear_o = uv_rst_reg;
    assign uv_level_o = uv_level_opt_i;
    assign warn_level_o = thr_reg;
    assign rc_prescaler_o = presc_reg;
    assign osc_trim_low_o = trim_reg;
    // gated by enable and global mask
    assign warn_irq_o = pend_reg & irq_en_reg & ~cpu_irq_mask_i;
    // wakes from wait; never from halt
    assign warn_wake_o = pend_reg & wait_mode_i & ~halt_mode_i;

    // ========================================================
    // checks

    // ========================================================
    // reset and pin checks
    // reset follows detector
    uv_reset_follow_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) uv_active |=> uv_core_reset_o)
        else $error("undervoltage reset not asserted");
    uv_release_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) !uv_active |=> !uv_core_reset_o)
        else $error("undervoltage reset not released");
    pin_drive_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) uv_core_reset_o |-> ext_reset_n_oe_o && !ext_reset_n_o)
        else $error("reset pin not driven low");
    pin_idle_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) !uv_core_reset_o |-> !ext_reset_n_oe_o)
        else $error("reset pin driven while idle");
    wdg_clear_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) uv_active |=> wdg_flag_clear_o)
        else $error("watchdog flag not cleared");
    wdg_idle_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) !uv_rst_reg |-> !wdg_flag_clear_o)
        else $error("watchdog flag cleared without cause");
    level_pass_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) uv_level_o == uv_level_opt_i)
        else $error("option level not passed");
    opt_gate_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) !uv_detect_enable_i |=> !uv_core_reset_o)
        else $error("disabled detector caused reset");

    // ========================================================
    // cause flag checks
    // flag set
    flag_set_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) uv_active |=> uv_flag_reg)
        else $error("cause flag not set");
    flag_clear_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            csr_rd && !csr_frozen && !uv_active |=> !uv_flag_reg)
        else $error("cause flag not cleared by read");
    flag_rise_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) $rose(uv_flag_reg) |-> $past(uv_active))
        else $error("cause flag set without detector");
    flag_hold_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            uv_flag_reg && !csr_rd && (wdg_reset_i || ext_reset_i) |=> uv_flag_reg)
        else $error("cause flag lost on other reset");
    flag_keep_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) uv_flag_reg && !csr_rd |=> uv_flag_reg)
        else $error("cause flag lost before read");
    flag_quiet_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            !uv_detect_enable_i && !uv_flag_reg |=> !uv_flag_reg)
        else $error("cause flag set while detector disabled");

    // ========================================================
    // warning and interrupt checks
    // status follows comparator
    warn_live_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) ##2 csr_view[1] == $past(warn_cmp_low_i, 2))
        else $error("warning flag not live");
    edge_pend_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) warn_edge && irq_en_reg |=> pend_reg)
        else $error("crossing did not pend");
    rise_pend_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            $rose(warn_sync) && warn_on && irq_en_reg |=> pend_reg)
        else $error("supply drop did not pend");
    fall_pend_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            $fell(warn_sync) && warn_on && irq_en_reg |=> pend_reg)
        else $error("supply recovery did not pend");
    irq_gate_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) warn_irq_o |-> irq_en_reg && !cpu_irq_mask_i)
        else $error("interrupt not gated");
    irq_reach_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            pend_reg && irq_en_reg && !cpu_irq_mask_i |-> warn_irq_o)
        else $error("enabled interrupt not raised");
    ack_clear_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) irq_vector_ack_i && !warn_edge |=> !pend_reg)
        else $error("pending not cleared at vector entry");
    wait_wake_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            pend_reg && wait_mode_i && !halt_mode_i |-> warn_wake_o)
        else $error("no wake from wait");
    halt_wake_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) halt_mode_i |-> !warn_wake_o)
        else $error("woke from halt");

    // ========================================================
    // register field checks
    // enable bit written
    ie_write_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            csr_wr && !csr_frozen && !uv_rst_reg |=> irq_en_reg == $past(req.pwdata[sim_pkg::CSR_IE_BIT]))
        else $error("interrupt enable not written");
    halt_freeze_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            halt_mode_i && csr_wr |=> $stable(irq_en_reg) && $stable(trim_reg))
        else $error("control/status changed in halt");
    thr_reset_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) $rose(uv_rst_reg) |=> thr_reg == sim_pkg::SIM_THR_OFF)
        else $error("threshold not off");
    off_quiet_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) thr_reg == sim_pkg::SIM_THR_OFF |-> !warn_edge)
        else $error("crossing seen with detector off");
    thr_write_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            thr_wr && !uv_rst_reg |=> thr_reg == $past(req.pwdata[sim_pkg::THR_FIELD_LSB +: 2]))
        else $error("threshold field not written");
    presc_write_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            thr_wr && !uv_rst_reg |=> presc_reg == $past(req.pwdata[sim_pkg::THR_PRESC_LSB +: 3]))
        else $error("prescaler select not written");
    trim_write_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i)
            csr_wr && !csr_frozen && !uv_rst_reg |=> trim_reg == $past(req.pwdata[sim_pkg::CSR_TRIM_LSB +: 2]))
        else $error("trim bits not written");
    // unmapped access flagged
    unmapped_err_a:
        assert property (@(posedge mclk_i) disable iff (sys_rst_i) access && !(csr_hit || thr_hit) |-> pslverr_o)
        else $error("unmapped access not flagged");
endmodule

// [core/sim_pkg.sv]
// package: register map, field positions, reset values and apb carriers for the supply integrity monitor
package sim_pkg;
    // ========================================================
    // register indices; each register is one aligned word, so the byte address is four times the index
    localparam logic [7:0] CSR_OFS = 8'h3a;
    localparam logic [7:0] THR_OFS = 8'h3e;
    localparam logic [7:0] CSR_ADDR = 8'he8;
    localparam logic [7:0] THR_ADDR = 8'hf8;
    // ========================================================
    // control/status fields
    localparam int CSR_IE_BIT = 0;
    localparam int CSR_WARN_BIT = 1;
    localparam int CSR_LVRF_BIT = 2;
    localparam int CSR_TRIM_LSB = 5;
    // threshold select fields
    localparam int THR_FIELD_LSB = 0;
    localparam int THR_PRESC_LSB = 5;
    // ========================================================
    // reset values
    localparam logic [1:0] TRIM_RST = 2'h3;
    localparam logic [1:0] THR_RST = 2'h3;
    localparam logic [2:0] PRESC_RST = 3'h0;
    localparam logic [7:0] THR_REG_RST = 8'h03;
    // ========================================================
    // threshold codes
    typedef enum logic [1:0] {
        SIM_THR_LOW = 2'b00,
        SIM_THR_MED = 2'b01,
        SIM_THR_HIGH = 2'b10,
        SIM_THR_OFF = 2'b11
    } sim_thr_e;
    // ========================================================
    // apb request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sim_apb_req_s;
endpackage

// [core/sim_sync.sv]
// two-flop synchroniser for an asynchronous level
module sim_sync (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // level
    input wire logic async_i,
    output logic sync_o
);
    logic meta_reg;
    logic sync_reg;

    // only the second flop is read outside
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

// [tb/testbench.sv]
// self-checking testbench for the supply integrity monitor
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // stimulus and observation
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, uv_cmp_low_i = 1'b0, warn_cmp_low_i = 1'b0;
    logic uv_detect_enable_i = 1'b1, wdg_reset_i = 1'b0, ext_reset_i = 1'b0, cpu_irq_mask_i = 1'b0;
    logic irq_vector_ack_i = 1'b0, halt_mode_i = 1'b0, wait_mode_i = 1'b0;
    logic [1:0] uv_level_opt_i = 2'h0;
    sim_pkg::sim_apb_req_s req = '0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, uv_core_reset_o, ext_reset_n_o, ext_reset_n_oe_o, wdg_flag_clear_o;
    logic warn_irq_o, warn_wake_o;
    logic [1:0] uv_level_o, warn_level_o, osc_trim_low_o;
    logic [2:0] rc_prescaler_o;
    int bad_count = 0, checks_done = 0;
    logic [31:0] exp_q[$];
    logic err_q[$];
    logic [7:0] csr_a, thr_a, v;
    sim_supply_integrity_monitor i_sim_supply_integrity_monitor (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .psel_i(req.psel), .penable_i(req.penable), .pwrite_i(req.pwrite), .paddr_i(req.paddr),
        .pwdata_i(req.pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .uv_cmp_low_i(uv_cmp_low_i), .warn_cmp_low_i(warn_cmp_low_i), .uv_detect_enable_i(uv_detect_enable_i),
        .uv_level_opt_i(uv_level_opt_i), .wdg_reset_i(wdg_reset_i), .ext_reset_i(ext_reset_i),
        .cpu_irq_mask_i(cpu_irq_mask_i), .irq_vector_ack_i(irq_vector_ack_i), .halt_mode_i(halt_mode_i),
        .wait_mode_i(wait_mode_i), .uv_core_reset_o(uv_core_reset_o), .ext_reset_n_o(ext_reset_n_o),
        .ext_reset_n_oe_o(ext_reset_n_oe_o), .wdg_flag_clear_o(wdg_flag_clear_o), .uv_level_o(uv_level_o),
        .warn_level_o(warn_level_o), .rc_prescaler_o(rc_prescaler_o), .osc_trim_low_o(osc_trim_low_o),
        .warn_irq_o(warn_irq_o), .warn_wake_o(warn_wake_o));
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    // ==========================================
    // verdict and comparison
    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // read results are taken off the queue at the edge where the access completes
    always @(posedge mclk_i) begin
        if (req.psel && req.penable && pready_o === 1'b1 && !req.pwrite) begin
            if (err_q.pop_front()) begin
                chk(pslverr_o, 1, "unmapped error");
                void'(exp_q.pop_front());
            end else begin
                chk(pslverr_o, 0, "read error");
                chk(prdata_o, exp_q.pop_front(), "read data");
            end
        end
    end
    // ==========================================
    // apb master and bounded waits
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic er = 0);
        int n;
        n = 0;
        if (!wr) begin
            exp_q.push_back(d);
            err_q.push_back(er);
        end
        @(posedge mclk_i);
        req <= '{1'b1, 1'b0, wr, a, wr ? d : 32'h0};
        @(posedge mclk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic wait_irq(input logic lvl);
        int n;
        for (n = 0; n < 12 && warn_irq_o !== lvl; n++) begin
            @(posedge mclk_i);
        end
        chk(warn_irq_o, lvl, "irq level");
        if (warn_irq_o !== lvl) begin
            complete_run();
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'hd2b27675));
        csr_a = sim_pkg::CSR_ADDR;
        thr_a = sim_pkg::THR_ADDR;
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        apb(0, csr_a, 32'h60);
        apb(0, thr_a, 32'h03);
        apb(0, 8'h10, 32'h0, 1);
        // option level passes through, detector gated by option
        uv_level_opt_i <= 2'($urandom);
        uv_detect_enable_i <= 1'b0;
        uv_cmp_low_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(uv_level_o, uv_level_opt_i, "uv level");
        chk(uv_core_reset_o, 0, "disabled detector");
        uv_detect_enable_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk(uv_core_reset_o, 1, "static reset");
        chk({ext_reset_n_oe_o, ext_reset_n_o}, 2'b10, "pin low");
        chk(wdg_flag_clear_o, 1, "wdg flag clear");
        ext_reset_i <= 1'b1;
        wdg_reset_i <= 1'b1;
        uv_cmp_low_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        ext_reset_i <= 1'b0;
        wdg_reset_i <= 1'b0;
        chk({uv_core_reset_o, ext_reset_n_oe_o}, 0, "reset released");
        apb(0, csr_a, 32'h64);
        apb(0, csr_a, 32'h60);
        for (int c = 0; c < 4; c++) begin
            v = {3'($urandom), 3'h0, 2'(c)};
            apb(1, thr_a, {24'h0, v});
            apb(0, thr_a, {24'h0, v});
            @(posedge mclk_i);
            chk({rc_prescaler_o, warn_level_o}, {v[7:5], v[1:0]}, "thr outputs");
        end
        apb(1, thr_a, 32'h00);
        apb(1, csr_a, 32'h21);
        @(posedge mclk_i);
        chk(osc_trim_low_o, 2'b01, "trim bits");
        warn_cmp_low_i <= 1'b1;
        wait_irq(1);
        apb(0, csr_a, 32'h23);
        irq_vector_ack_i <= 1'b1;
        @(posedge mclk_i);
        irq_vector_ack_i <= 1'b0;
        wait_irq(0);
        cpu_irq_mask_i <= 1'b1;
        warn_cmp_low_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        chk(warn_irq_o, 0, "masked irq");
        cpu_irq_mask_i <= 1'b0;
        wait_irq(1);
        wait_mode_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk(warn_wake_o, 1, "wake from wait");
        halt_mode_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk(warn_wake_o, 0, "no halt wake");
        apb(1, csr_a, 32'h00);
        apb(0, csr_a, 32'h21);
        halt_mode_i <= 1'b0;
        wait_mode_i <= 1'b0;
        apb(1, csr_a, 32'h20);
        wait_irq(0);
        warn_cmp_low_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        chk(warn_irq_o, 0, "disabled irq");
        complete_run();
    end
endmodule
